// [sfh_pkg.sv]
/*
  Constants, command table and carrier types for the serial flash read host.
  Assumes a 100 MHz system clock and a device that samples on the rising
  serial clock edge and launches on the falling edge.
*/

`default_nettype none

package sfh_pkg;

  // ************************************************************
  // Opcodes and phase lengths
  // ************************************************************
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_WORD_QUAD = 8'he7;
  localparam logic [7:0] OP_VSR_WEN = 8'h50;
  localparam logic [19:0] OPCODE_CLKS = 20'h8;
  localparam logic [19:0] ADDR_CLKS_X1 = 20'h18;
  localparam logic [19:0] ADDR_CLKS_X2 = 20'hc;
  localparam logic [19:0] ADDR_CLKS_X4 = 20'h6;
  localparam logic [3:0] MODE_CLKS_X2 = 4'h4;
  localparam logic [3:0] MODE_CLKS_X4 = 4'h2;
  localparam logic [3:0] DUMMY_OUT_READ = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h4;
  localparam logic [3:0] DUMMY_WORD_QUAD = 4'h2;
  localparam logic [2:0] UPPER_ADDRESS_BITS_VALUE = 3'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int MCLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS = 40;
  localparam int CS_HIGH_NS = 50;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + MCLK_PERIOD_NS - 1)
    / MCLK_PERIOD_NS;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + MCLK_PERIOD_NS - 1)
    / MCLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    SFH_DUAL_OUT,
    SFH_QUAD_OUT,
    SFH_DUAL_IO,
    SFH_QUAD_IO,
    SFH_WORD_QUAD,
    SFH_VSR_WEN
  } sfh_kind_t;

  typedef enum logic [3:0] {
    PH_IDLE,
    PH_OP,
    PH_ADDR,
    PH_MODE,
    PH_DUMMY,
    PH_DATA,
    PH_TAIL,
    PH_GAP
  } sfh_phase_t;

  typedef struct packed {
    sfh_kind_t kind;
    logic cont;
    logic [20:0] addr;
    logic [7:0] mode;
    logic [15:0] nbytes;
  } sfh_cmd_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic [3:0] mode_clks;
    logic [3:0] dummy_clks;
    logic has_addr;
  } sfh_desc_t;

  typedef struct packed {
    sfh_phase_t ph;
    logic [19:0] clks;
  } sfh_seg_t;

  function automatic sfh_desc_t sfh_describe(input sfh_kind_t k);
    sfh_desc_t d;
    d = '{OP_VSR_WEN, 3'h1, 3'h1, 4'h0, 4'h0, 1'b0};
    unique case (k)
      SFH_DUAL_OUT: d = '{OP_DUAL_OUT, 3'h1, 3'h2, 4'h0, DUMMY_OUT_READ,
        1'b1};
      SFH_QUAD_OUT: d = '{OP_QUAD_OUT, 3'h1, 3'h4, 4'h0, DUMMY_OUT_READ,
        1'b1};
      SFH_DUAL_IO: d = '{OP_DUAL_IO, 3'h2, 3'h2, MODE_CLKS_X2, 4'h0,
        1'b1};
      SFH_QUAD_IO: d = '{OP_QUAD_IO, 3'h4, 3'h4, MODE_CLKS_X4,
        DUMMY_QUAD_IO, 1'b1};
      SFH_WORD_QUAD: d = '{OP_WORD_QUAD, 3'h4, 3'h4, MODE_CLKS_X4,
        DUMMY_WORD_QUAD, 1'b1};
      SFH_VSR_WEN: d = '{OP_VSR_WEN, 3'h1, 3'h1, 4'h0, 4'h0,
        1'b0};
      default: d = '{OP_VSR_WEN, 3'h1, 3'h1, 4'h0, 4'h0, 1'b0};
    endcase
    return d;
  endfunction : sfh_describe

endpackage : sfh_pkg

`default_nettype wire

// [sfh_host.sv]
/*
  Serial flash read host: takes one command at a time, frames it on the
  four-lane serial bus and returns read bytes.
  Assumes the serial clock it makes is the only clock the device sees and
  that lane inputs are asynchronous to the system clock.
*/

`default_nettype none

module sfh_host
  import sfh_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire sfh_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_busy,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_cs_n,
  output logic o_sck,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe,
  input wire logic [3:0] i_io
);

  // ************************************************************
  // State
  // ************************************************************
  sfh_phase_t phase, next_phase;
  sfh_desc_t desc, next_desc;
  logic [15:0] nbytes, next_nbytes;
  logic [7:0] div, next_div;
  logic [19:0] clk_left, next_clk_left;
  logic [39:0] tx, next_tx;
  logic [7:0] rx, next_rx;
  logic [3:0] rx_bits, next_rx_bits;
  logic rd_valid, next_rd_valid;
  logic [7:0] rd_data, next_rd_data;
  logic cs_n, next_cs_n;
  logic sck, next_sck;
  logic [3:0] io, next_io;
  logic [3:0] io_oe, next_io_oe;
  logic [3:0] io_meta, io_sync;
  sfh_seg_t seg;
  sfh_desc_t d_new;

  // ************************************************************
  // Phase sequencing
  // ************************************************************
  // Works out which phase follows the given one and how many serial
  // clocks it lasts; phases with no clocks are skipped.
  function automatic sfh_seg_t next_seg(input sfh_phase_t p,
                                        input sfh_desc_t d,
                                        input logic [15:0] nb);
    sfh_seg_t s;
    logic [2:0] rank;
    s.ph = PH_TAIL;
    s.clks = 20'h0;
    rank = 3'h0;
    // Data ranks last, so leaving it always ends the frame at the tail.
    unique case (p)
      PH_ADDR: rank = 3'h1;
      PH_MODE: rank = 3'h2;
      PH_DUMMY: rank = 3'h3;
      PH_DATA: rank = 3'h4;
      default: rank = 3'h0;
    endcase
    if (rank < 3'h1 && d.has_addr)
    begin
      s.ph = PH_ADDR;
      unique case (d.addr_lanes)
        3'h2: s.clks = ADDR_CLKS_X2;
        3'h4: s.clks = ADDR_CLKS_X4;
        default: s.clks = ADDR_CLKS_X1;
      endcase
    end
    else if (rank < 3'h2 && d.mode_clks != 4'h0)
    begin
      s.ph = PH_MODE;
      s.clks = {16'h0, d.mode_clks};
    end
    else if (rank < 3'h3 && d.dummy_clks != 4'h0)
    begin
      s.ph = PH_DUMMY;
      s.clks = {16'h0, d.dummy_clks};
    end
    else if (rank < 3'h4 && d.has_addr && nb != 16'h0)
    begin
      s.ph = PH_DATA;
      unique case (d.data_lanes)
        3'h2: s.clks = {2'h0, nb, 2'h0};
        3'h4: s.clks = {3'h0, nb, 1'h0};
        default: s.clks = {1'h0, nb, 3'h0};
      endcase
    end
    return s;
  endfunction : next_seg

  assign o_cmd_ready = (phase == PH_IDLE);
  assign o_busy = (phase != PH_IDLE);
  assign o_rd_valid = rd_valid;
  assign o_rd_data = rd_data;
  assign o_cs_n = cs_n;
  assign o_sck = sck;
  assign o_io = io;
  assign o_io_oe = io_oe;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    next_phase = phase;
    next_desc = desc;
    next_nbytes = nbytes;
    next_div = div;
    next_clk_left = clk_left;
    next_tx = tx;
    next_rx = rx;
    next_rx_bits = rx_bits;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_sck = sck;
    seg = '{PH_TAIL, 20'h0};
    d_new = sfh_describe(i_cmd.kind);
    unique case (phase)
      PH_IDLE:
      begin
        next_sck = 1'b0;
        if (i_cmd_valid)
        begin
          next_desc = d_new;
          next_nbytes = i_cmd.nbytes;
          next_div = 8'h0;
          next_rx_bits = 4'h0;
          if (i_cmd.cont && d_new.mode_clks != 4'h0)
          begin
            next_tx = {UPPER_ADDRESS_BITS_VALUE, i_cmd.addr, i_cmd.mode,
              8'h0};
            seg = next_seg(PH_OP, d_new, i_cmd.nbytes);
            next_phase = seg.ph;
            next_clk_left = seg.clks;
          end
          else
          begin
            next_tx = {d_new.opcode, UPPER_ADDRESS_BITS_VALUE, i_cmd.addr,
              i_cmd.mode};
            next_phase = PH_OP;
            next_clk_left = OPCODE_CLKS;
          end
        end
      end
      PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA:
      begin
        next_div = div + 8'h1;
        if (div == 8'(SCK_HALF_CYC - 1))
        begin
          next_div = 8'h0;
          next_sck = ~sck;
          if (!sck && phase == PH_DATA)
          begin
            // Rising edge: take the lanes the device launched.
            unique case (desc.data_lanes)
              3'h2: next_rx = {rx[5:0], io_sync[1:0]};
              3'h4: next_rx = {rx[3:0], io_sync};
              default: next_rx = {rx[6:0], io_sync[1]};
            endcase
            next_rx_bits = rx_bits + {1'b0, desc.data_lanes};
            if (next_rx_bits == 4'h8)
            begin
              next_rx_bits = 4'h0;
              next_rd_valid = 1'b1;
              next_rd_data = next_rx;
            end
          end
          else if (sck)
          begin
            // Falling edge: launch the next bits.
            unique case (phase)
              PH_OP: next_tx = {tx[38:0], 1'b0};
              PH_ADDR, PH_MODE:
              begin
                unique case (desc.addr_lanes)
                  3'h2: next_tx = {tx[37:0], 2'h0};
                  3'h4: next_tx = {tx[35:0], 4'h0};
                  default: next_tx = {tx[38:0], 1'b0};
                endcase
              end
              default: next_tx = tx;
            endcase
            next_clk_left = clk_left - 20'h1;
            if (clk_left == 20'h1)
            begin
              seg = next_seg(phase, desc, nbytes);
              next_phase = seg.ph;
              next_clk_left = seg.clks;
            end
          end
        end
      end
      PH_TAIL:
      begin
        // Clock stays low for a half period before select rises.
        next_sck = 1'b0;
        next_div = div + 8'h1;
        if (div == 8'(SCK_HALF_CYC - 1))
        begin
          next_div = 8'h0;
          next_phase = PH_GAP;
        end
      end
      PH_GAP:
      begin
        next_div = div + 8'h1;
        if (div == 8'(CS_HIGH_CYC - 1))
        begin
          next_div = 8'h0;
          next_phase = PH_IDLE;
        end
      end
    endcase
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Lanes are released before dummy and data so the device never meets
  // a driven lane; the host makes no use of the dummy lanes.
  always_comb
  begin
    next_cs_n = (next_phase == PH_IDLE) || (next_phase == PH_GAP);
    next_io = 4'h0;
    next_io_oe = 4'h0;
    unique case (next_phase)
      PH_OP:
      begin
        next_io = {3'h0, next_tx[39]};
        next_io_oe = 4'h1;
      end
      PH_ADDR, PH_MODE:
      begin
        unique case (next_desc.addr_lanes)
          3'h2:
          begin
            next_io = {2'h0, next_tx[39:38]};
            next_io_oe = 4'h3;
          end
          3'h4:
          begin
            next_io = next_tx[39:36];
            next_io_oe = 4'hf;
          end
          default:
          begin
            next_io = {3'h0, next_tx[39]};
            next_io_oe = 4'h1;
          end
        endcase
      end
      default:
      begin
        next_io = 4'h0;
        next_io_oe = 4'h0;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_mclk)
  begin
    io_meta <= i_io;
    io_sync <= io_meta;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      phase <= PH_IDLE;
      desc <= '0;
      nbytes <= 16'h0;
      div <= 8'h0;
      clk_left <= 20'h0;
      tx <= 40'h0;
      rx <= 8'h0;
      rx_bits <= 4'h0;
      rd_valid <= 1'b0;
      rd_data <= 8'h0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      io <= 4'h0;
      io_oe <= 4'h0;
    end
    else
    begin
      phase <= next_phase;
      desc <= next_desc;
      nbytes <= next_nbytes;
      div <= next_div;
      clk_left <= next_clk_left;
      tx <= next_tx;
      rx <= next_rx;
      rx_bits <= next_rx_bits;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      cs_n <= next_cs_n;
      sck <= next_sck;
      io <= next_io;
      io_oe <= next_io_oe;
    end
  end

endmodule : sfh_host

`default_nettype wire

// [sfh_host_checker.sv]
/*
  Port timing checker for sfh_host.
  Assumes one clock domain; it is bound to every sfh_host instance.
*/
`default_nettype none

module sfh_host_checker
  import sfh_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_cmd_valid,
  input wire sfh_cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_busy,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic o_cs_n,
  input wire logic o_sck,
  input wire logic [3:0] o_io,
  input wire logic [3:0] o_io_oe,
  input wire logic [3:0] i_io
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);

  chk_sck_idle_low:
    assert property (o_cs_n |-> !o_sck)
    else $error("serial clock not low while deselected");
  chk_io_launch:
    assert property (!o_cs_n && !$stable(o_io) |-> !o_sck)
    else $error("lane changed while serial clock high");
  chk_sck_high:
    assert property ($rose(o_sck) |-> o_sck [*4] ##1 !o_sck)
    else $error("serial clock high time wrong");
  chk_cs_take:
    assert property (i_cmd_valid && o_cmd_ready |=> !o_cs_n)
    else $error("select not asserted after command");
  chk_oe_legal:
    assert property (!o_cs_n |-> o_io_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("illegal lane enable set");
  chk_rd_frame:
    assert property (o_rd_valid |-> !o_cs_n)
    else $error("read byte outside a frame");
  chk_cs_gap:
    assert property ($rose(o_cs_n) |-> o_cs_n [*5])
    else $error("select high time too short");
  chk_oe_release:
    assert property (o_cs_n |-> o_io_oe == 4'h0)
    else $error("lanes driven while deselected");

endmodule : sfh_host_checker

bind sfh_host sfh_host_checker u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
  .o_busy(o_busy), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .o_cs_n(o_cs_n), .o_sck(o_sck), .o_io(o_io), .o_io_oe(o_io_oe),
  .i_io(i_io));

`default_nettype wire

// [sfh_flash_model.sv]
/*
  Behavioural model of the serial flash read path.
  Assumes the bench resolves the lanes, with pull-ups where none drives.
*/
`default_nettype none

module sfh_flash_model #(
  // Mode byte that keeps the next access opcode-free; value is arbitrary.
  parameter logic [7:0] CONT_MD = 8'ha0
)
(
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic [3:0] o_io_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Frame decode and data launch
  // ************************************************************
  logic [7:0] op, md, sh;
  logic [23:0] adr;
  logic [3:0] msk;
  logic cont = 1'b0;
  logic dead = 1'b0;
  int cnt = 0;
  int st = 99;
  int al, dl, mc, dc, j;

  function automatic logic [7:0] byte_at(input logic [20:0] a);
    return a[7:0] ^ {3'h0, a[20:16]} ^ 8'h3c;
  endfunction : byte_at

  task automatic set(input int a, d, m, w);
    al = a;
    dl = d;
    mc = m;
    dc = w;
    st = 8 + 24 / a + m + w;
  endtask : set

  initial
  begin
    o_io = 4'h0;
    o_io_oe = 4'h0;
  end

  always @(negedge i_cs_n)
  begin
    cnt = cont ? 8 : 0;
    dead = 1'b0;
  end

  // A frame cut short leaves cnt below st, so no continuous state is kept.
  always @(posedge i_cs_n)
  begin
    o_io_oe = 4'h0;
    cont = !dead && mc != 0 && cnt >= st && md == CONT_MD;
  end

  always @(posedge i_sck)
  if (!i_cs_n && !dead)
  begin
    msk = (4'h1 << al) - 4'h1;
    if (cnt < 8)
      op = {op[6:0], i_io[0]};
    else if (cnt < 8 + 24 / al)
      adr = (adr << al) | 24'(i_io & msk);
    else if (cnt < 8 + 24 / al + mc)
      md = (md << al) | 8'(i_io & msk);
    cnt++;
    if (cnt == 8)
      case (op)
        8'h3b: set(1, 2, 0, 8);
        8'h6b: set(1, 4, 0, 8);
        8'hbb: set(2, 2, 4, 0);
        8'heb: set(4, 4, 2, 4);
        8'he7: set(4, 4, 2, 2);
        default: dead = 1'b1;
      endcase
  end

  always @(negedge i_sck)
  if (!i_cs_n && !dead && cnt >= st)
  begin
    j = cnt - st;
    if (j % (8 / dl) == 0)
      sh = byte_at(adr[20:0] + 21'(j / (8 / dl)));
    else
      sh = sh << dl;
    o_io = dl == 2 ? {2'b00, sh[7:6]} : sh[7:4];
    o_io_oe = dl == 2 ? 4'h3 : 4'hf;
  end

endmodule : sfh_flash_model

`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for sfh_host against the flash model.
  Assumes pull-ups on all four lanes.
*/
`default_nettype none

module tb
  import sfh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Bench
  // ************************************************************
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_cmd_valid = 1'b0;
  sfh_cmd_t i_cmd = '0;
  logic o_cmd_ready, o_busy, o_rd_valid, o_cs_n, o_sck;
  logic [7:0] o_rd_data;
  logic [3:0] o_io, o_io_oe, i_io, dev_io, dev_oe;
  int errors = 0;
  int check_count = 0;

  always #5 i_mclk = ~i_mclk;

  always_comb
    for (int b = 0; b < 4; b++)
      i_io[b] = o_io_oe[b] ? o_io[b] : dev_oe[b] ? dev_io[b] : 1'b1;

  sfh_host DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_busy(o_busy),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_cs_n(o_cs_n),
    .o_sck(o_sck), .o_io(o_io), .o_io_oe(o_io_oe), .i_io(i_io));
  sfh_flash_model FLASH (.i_cs_n(o_cs_n), .i_sck(o_sck), .i_io(i_io),
    .o_io(dev_io), .o_io_oe(dev_oe));

  task automatic chk(input logic [23:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Bytes are judged as they come, so a late or missing pulse shows here.
  task automatic run(input sfh_kind_t k, input logic c,
    input logic [20:0] a, input logic [7:0] m, input logic [15:0] n,
    input logic [7:0] op);
    int i;
    int t;
    i = 0;
    @(posedge i_mclk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{k, c, a, m, n};
    @(posedge i_mclk);
    i_cmd_valid <= 1'b0;
    for (t = 0; t < 5000; t++)
    begin
      @(negedge i_mclk);
      if (t == 0)
        chk(24'(o_busy), 24'h1);
      if (o_rd_valid === 1'b1)
      begin
        chk(24'(o_rd_data), 24'(FLASH.byte_at(a + 21'(i))));
        i++;
      end
      if (o_cmd_ready === 1'b1)
        break;
    end
    if (t == 5000)
    begin
      errors++;
      $display("ERROR %0t: command did not finish", $time);
      close_out();
    end
    chk(24'(o_busy), 24'h0);
    chk(24'(i), 24'(n));
    if (!c)
      chk(24'(FLASH.op), 24'(op));
    if (k != SFH_VSR_WEN)
      chk(FLASH.adr, {3'h0, a});
  endtask : run

  task automatic s_out_reads();
    run(SFH_DUAL_OUT, 1'b1, 21'h1ffffe, 8'h00, 16'h3, OP_DUAL_OUT);
    run(SFH_QUAD_OUT, 1'b0, 21'h0a5a5a, 8'h00, 16'h4, OP_QUAD_OUT);
  endtask : s_out_reads

  task automatic s_dual_io();
    run(SFH_DUAL_IO, 1'b0, 21'h123456, 8'ha0, 16'h2, OP_DUAL_IO);
    run(SFH_DUAL_IO, 1'b1, 21'h000001, 8'h00, 16'h2, OP_DUAL_IO);
  endtask : s_dual_io

  task automatic s_quad_io();
    run(SFH_QUAD_IO, 1'b0, 21'h0fedcb, 8'ha0, 16'h3, OP_QUAD_IO);
    run(SFH_QUAD_IO, 1'b1, 21'h1000ff, 8'h00, 16'h1, OP_QUAD_IO);
  endtask : s_quad_io

  task automatic s_word_and_wen();
    run(SFH_WORD_QUAD, 1'b0, 21'h054321, 8'h00, 16'h2, OP_WORD_QUAD);
    run(SFH_WORD_QUAD, 1'b0, 21'h000010, 8'h00, 16'h0, OP_WORD_QUAD);
    run(SFH_VSR_WEN, 1'b0, 21'h000000, 8'h00, 16'h0, OP_VSR_WEN);
    run(SFH_QUAD_OUT, 1'b0, 21'h000abc, 8'h00, 16'h1, OP_QUAD_OUT);
  endtask : s_word_and_wen

  initial
  begin
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    chk(24'({o_cs_n, o_sck, o_io_oe, o_cmd_ready}), 24'h41);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    s_out_reads();
    s_dual_io();
    s_quad_io();
    s_word_and_wen();
    close_out();
  end

endmodule : tb

`default_nettype wire
